// ### src/bhm_defines.svh
// timing and width constants for the byte hardware multiplier
`ifndef BHM_DEFINES_SVH
`define BHM_DEFINES_SVH
`define BHM_OPERAND_W   8
`define BHM_PRODUCT_W   16
`define BHM_RESET_BYTE  8'h00
`define BHM_STATUS_W    5
`define BHM_STATUS_RST  5'h00
`define BHM_MUL_CYCLES  1
`endif

// ### src/bhm_pkg.sv
// types shared by the byte hardware multiplier files
`include "bhm_defines.svh"
package bhm_pkg;
   typedef struct packed {
      logic [`BHM_OPERAND_W-1:0] high;
      logic [`BHM_OPERAND_W-1:0] low;
   } bhm_product_t;
   typedef struct packed {
      bhm_product_t              product;
      logic [`BHM_STATUS_W-1:0] status;
      logic                      done;
   } bhm_state_t;
endpackage : bhm_pkg

// ### src/bhm_array_mult.sv
// unsigned shift-and-add array multiplier, purely combinational
`timescale 1ns/1ps
`include "bhm_defines.svh"
module bhm_array_mult import bhm_pkg::*; #(
   parameter int WIDTH = `BHM_OPERAND_W
) (
   // operands
   input  wire logic [WIDTH-1:0]   op_a,
   input  wire logic [WIDTH-1:0]   op_b,
   // full product
   output logic      [2*WIDTH-1:0] product
);
   logic [2*WIDTH-1:0] partial [WIDTH+1];

   assign partial[0] = '0;
   // one partial product per bit of op_b, no sign extension anywhere
   genvar gi;
   for (gi = 0; gi < WIDTH; gi++) begin : g_row
      logic [2*WIDTH-1:0] term;
      assign term = op_b[gi] ? ({{WIDTH{1'b0}}, op_a} << gi) : '0;
      assign partial[gi+1] = partial[gi] + term;
   end
   assign product = partial[WIDTH];
endmodule : bhm_array_mult

// ### src/bhm_multiplier.sv
// byte hardware multiplier: product register pair behind the ALU
//
// How it works
// - both bytes are unsigned; full product, no sign logic in hardware
// - upper product byte goes to high register, lower to low register
// - a multiply never changes any status flag
// - product is registered at the end of the one multiply cycle
// - one operand is the working register, the other the instr operand
`timescale 1ns/1ps
`include "bhm_defines.svh"
module bhm_multiplier import bhm_pkg::*; #(
   parameter int WIDTH = `BHM_OPERAND_W
) (
   // clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // multiply issue from the instruction decoder
   input  wire logic                     multiply_by_working_instr,
   input  wire logic [WIDTH-1:0]         working_register,
   input  wire logic [WIDTH-1:0]         instr_operand,
   // explicit writes to the product registers
   input  wire logic                     wr_high_en,
   input  wire logic                     wr_low_en,
   input  wire logic [WIDTH-1:0]         wr_data,
   // status flags computed by the rest of the alu
   input  wire logic                     status_wr_en,
   input  wire logic [`BHM_STATUS_W-1:0] status_in,
   // results
   output logic      [WIDTH-1:0]         product_high_byte,
   output logic      [WIDTH-1:0]         product_low_byte,
   output logic      [`BHM_STATUS_W-1:0] status_flags,
   output logic                          mul_done
);
   bhm_state_t       st_reg;
   bhm_state_t       st_next;
   logic [2*WIDTH-1:0] raw_product;

   // operands taken straight from the working register and the instruction
   bhm_array_mult #(.WIDTH(WIDTH)) u_mult (
      .op_a    (working_register),
      .op_b    (instr_operand),
      .product (raw_product)
   );

   // next state: multiply beats an explicit write in the same cycle,
   // since the decoder only issues one instruction per cycle anyway
   always_comb begin
      st_next      = st_reg;
      st_next.done = 1'b0;
      if (multiply_by_working_instr) begin
         st_next.product.high = raw_product[2*WIDTH-1:WIDTH];
         st_next.product.low  = raw_product[WIDTH-1:0];
         st_next.done         = 1'b1;
      end else begin
         if (wr_high_en) begin
            st_next.product.high = wr_data;
         end
         if (wr_low_en) begin
            st_next.product.low = wr_data;
         end
      end
      // flags are only touched by non-multiply instructions
      if (status_wr_en && !multiply_by_working_instr) begin
         st_next.status = status_in;
      end
   end

   // single state register, all outputs come from it
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_reg.product.high <= `BHM_RESET_BYTE;
         st_reg.product.low  <= `BHM_RESET_BYTE;
         st_reg.status       <= `BHM_STATUS_RST;
         st_reg.done         <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign product_high_byte = st_reg.product.high;
   assign product_low_byte  = st_reg.product.low;
   assign status_flags      = st_reg.status;
   assign mul_done          = st_reg.done;

   // product of the operands appears one edge after the issue
   a_mul_result: assert property (@(posedge clk_sys) disable iff (!rst_n)
      multiply_by_working_instr |=> {product_high_byte, product_low_byte}
         == $past(working_register) * $past(instr_operand))
      else $error("product does not match unsigned operands");

   a_high_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
      multiply_by_working_instr |=> product_high_byte
         == 8'(({8'h00, $past(working_register)} *
                {8'h00, $past(instr_operand)}) >> 8))
      else $error("high product byte wrong");

   a_flags_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
      multiply_by_working_instr |=> $stable(status_flags))
      else $error("multiply changed status flags");

   a_done_once: assert property (@(posedge clk_sys) disable iff (!rst_n)
      multiply_by_working_instr |=> mul_done)
      else $error("multiply did not finish in one cycle");

   a_done_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mul_done |-> $past(multiply_by_working_instr))
      else $error("done without multiply");

   a_working_register_operand: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (multiply_by_working_instr && instr_operand == 8'h01)
         |=> product_low_byte == $past(working_register)
             && product_high_byte == 8'h00)
      else $error("working register not used as operand");

   a_prod_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && !wr_high_en && !wr_low_en)
         |=> $stable({product_high_byte, product_low_byte}))
      else $error("product changed without cause");

   a_prod_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && wr_low_en)
         |=> product_low_byte == $past(wr_data))
      else $error("explicit low write lost");

   // low byte alone carries the product modulo 256
   a_low_byte: assert property (@(posedge clk_sys) disable iff (!rst_n)
      multiply_by_working_instr |=> product_low_byte
         == 8'($past(working_register) * $past(instr_operand)))
      else $error("low product byte wrong");

   // a zero working register must give a zero product
   a_zero_operand: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (multiply_by_working_instr && working_register == 8'h00)
         |=> {product_high_byte, product_low_byte} == 16'h0000)
      else $error("zero operand gave nonzero product");

   // both bytes all ones: a signed reading would give one, not FE01
   a_max_operand: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (multiply_by_working_instr && working_register == 8'hFF
         && instr_operand == 8'hFF)
         |=> {product_high_byte, product_low_byte} == 16'hFE01)
      else $error("all-ones operands not treated as unsigned");

   // other alu instructions still load the flags
   a_status_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (status_wr_en && !multiply_by_working_instr)
         |=> status_flags == $past(status_in))
      else $error("status load lost");

   // flags never move without a load request
   a_status_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !status_wr_en |=> $stable(status_flags))
      else $error("status flags changed without load");

   // in the cycle the product is shown, the flags are those of before
   a_done_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mul_done |-> $stable(status_flags))
      else $error("flags moved with the product");

   // done is a single pulse; no issue means no done next cycle
   a_done_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !multiply_by_working_instr |=> !mul_done)
      else $error("done stood without a multiply");

   // the second operand comes from the instruction, not the register
   a_operand_swap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (multiply_by_working_instr && working_register == 8'h01)
         |=> product_low_byte == $past(instr_operand)
             && product_high_byte == 8'h00)
      else $error("instruction operand not used");

   // explicit high write lands when no multiply competes
   a_high_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && wr_high_en)
         |=> product_high_byte == $past(wr_data))
      else $error("explicit high write lost");

   // a multiply in the same cycle overrides any explicit write,
   // so software never sees a half-written product pair
   a_mul_priority: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (multiply_by_working_instr && (wr_high_en || wr_low_en))
         |=> {product_high_byte, product_low_byte}
             == $past(working_register) * $past(instr_operand))
      else $error("write beat a multiply");

   // a write to one byte leaves the other byte alone
   a_low_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && wr_high_en && !wr_low_en)
         |=> $stable(product_low_byte))
      else $error("high write disturbed low byte");

   a_high_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && wr_low_en && !wr_high_en)
         |=> $stable(product_high_byte))
      else $error("low write disturbed high byte");

   // both enables together load the same byte into each half
   a_both_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && wr_high_en && wr_low_en)
         |=> product_high_byte == $past(wr_data)
             && product_low_byte == $past(wr_data))
      else $error("paired write lost");

   // low byte holds whenever nothing addresses it
   a_low_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (!multiply_by_working_instr && !wr_low_en)
         |=> $stable(product_low_byte))
      else $error("low byte drifted");

   // while reset is held the pair reads as zero; no stale product
   // survives a reset into the first instruction after it
   a_reset_clear: assert property (@(posedge clk_sys)
      !rst_n |-> {product_high_byte, product_low_byte} == 16'h0000
         && !mul_done)
      else $error("product not cleared in reset");
endmodule : bhm_multiplier

// ### bench/bhm_decoder_model.sv
// decoder model issuing multiply instructions
`timescale 1ns/1ps
module bhm_decoder_model (
   // clock
   input  wire logic       clk_sys,
   // multiply issue
   output logic            issue,
   output logic [7:0]      op_w,
   output logic [7:0]      op_k
);
   // quiet at time zero
   initial begin
      issue = 1'b0;
      op_w  = 8'h00;
      op_k  = 8'h00;
   end
   // one multiply per call; held to the taking edge
   task automatic mul(input logic [7:0] a, input logic [7:0] b);
      issue <= 1'b1;
      op_w  <= a;
      op_k  <= b;
      @(posedge clk_sys);
   endtask : mul
   // drop issue; stale op_w flips so it does not look held, op_k keeps its value
   task automatic idle();
      issue <= 1'b0;
      op_w  <= ~op_w;
      @(posedge clk_sys);
   endtask : idle
endmodule : bhm_decoder_model

// ### bench/byte_hardware_multiplier_tb_top.sv
// self-checking bench for the byte hardware multiplier
`timescale 1ns/1ps
`include "bhm_defines.svh"
module byte_hardware_multiplier_tb_top;
   logic                     clk_sys = 1'b0;
   logic                     rst_n = 1'b0;
   logic                     iss, wh = 0, wl = 0, swe = 0, done;
   logic [7:0]               opw, opk, wd = 8'h00, ph, pl;
   logic [`BHM_STATUS_W-1:0] sin = '0, sf;
   int                       n_errors = 0, comparisons = 0, cyc = 0;
   // clock and hang guard
   always #4 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         n_errors++;
         conclude();
      end
   end
   bhm_decoder_model u_bhm_decoder_model (.clk_sys(clk_sys), .issue(iss),
      .op_w(opw), .op_k(opk));
   bhm_multiplier u_bhm_multiplier (.clk_sys(clk_sys), .rst_n(rst_n),
      .multiply_by_working_instr(iss), .working_register(opw),
      .instr_operand(opk), .wr_high_en(wh), .wr_low_en(wl), .wr_data(wd),
      .status_wr_en(swe), .status_in(sin), .product_high_byte(ph),
      .product_low_byte(pl), .status_flags(sf), .mul_done(done));
   task automatic chk(input string s, input logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   // back to back, corner operands included
   task automatic t_mul();
      logic [7:0] a [5] = '{8'h00, 8'hFF, 8'h80, 8'hA5, 8'h01};
      logic [7:0] b [5] = '{8'hFF, 8'hFF, 8'h02, 8'h3C, 8'h01};
      for (int i = 0; i < 5; i++) begin
         u_bhm_decoder_model.mul(a[i], b[i]);
         #1 chk("product", 16'(a[i]) * 16'(b[i]), {ph, pl});
         chk("done", 16'h0001, {15'h0, done});
      end
      u_bhm_decoder_model.idle();
      #1 chk("held", 16'h0001, {ph, pl});
      chk("done low", 16'h0000, {15'h0, done});
      $display("test mul done");
   endtask : t_mul
   // flags loaded, then a multiply with a flag load in the same cycle
   task automatic t_flags();
      swe <= 1'b1;
      sin <= 5'h15;
      @(posedge clk_sys);
      #1 chk("flags", 16'h0015, {11'h0, sf});
      sin <= 5'h0A;
      u_bhm_decoder_model.mul(8'h10, 8'h10);
      #1 chk("flags kept", 16'h0015, {11'h0, sf});
      chk("bytes", 16'h0100, {ph, pl});
      swe <= 1'b0;
      u_bhm_decoder_model.idle();
      $display("test flags done");
   endtask : t_flags
   // explicit write, then write losing to a multiply
   task automatic t_write();
      wl <= 1'b1;
      wd <= 8'h3C;
      @(posedge clk_sys);
      #1 chk("write low", 16'h013C, {ph, pl});
      wl <= 1'b0;
      wh <= 1'b1;
      wd <= 8'h77;
      u_bhm_decoder_model.mul(8'h02, 8'h03);
      wh <= 1'b0;
      u_bhm_decoder_model.idle();
      repeat (3) @(posedge clk_sys);
      #1 chk("mul wins", 16'h0006, {ph, pl});
      wh <= 1'b1;
      wd <= 8'h5A;
      @(posedge clk_sys);
      #1 chk("write high", 16'h5A06, {ph, pl});
      wh <= 1'b0;
      @(posedge clk_sys);
      $display("test write done");
   endtask : t_write
   // software signed fix-up: subtract the other operand from the high byte
   task automatic t_signed();
      logic [7:0]  a [2] = '{8'hFB, 8'h80};
      logic [7:0]  b [2] = '{8'h07, 8'h80};
      logic [15:0] e [2] = '{16'hFFDD, 16'h4000};
      logic [7:0]  hi;
      for (int i = 0; i < 2; i++) begin
         u_bhm_decoder_model.mul(a[i], b[i]);
         #1 hi = ph;
         if (b[i][7]) hi = hi - a[i];
         if (a[i][7]) hi = hi - b[i];
         chk("signed", e[i], {hi, pl});
         u_bhm_decoder_model.idle();
      end
      $display("test signed done");
   endtask : t_signed
   // software 16x16 from four byte products with cross terms at 8 bits
   task automatic t_wide();
      logic [15:0] p [4];
      logic [31:0] res;
      u_bhm_decoder_model.mul(8'h34, 8'hCD);
      #1 p[0] = {ph, pl};
      u_bhm_decoder_model.mul(8'h12, 8'hAB);
      #1 p[1] = {ph, pl};
      u_bhm_decoder_model.mul(8'h34, 8'hAB);
      #1 p[2] = {ph, pl};
      u_bhm_decoder_model.mul(8'h12, 8'hCD);
      #1 p[3] = {ph, pl};
      u_bhm_decoder_model.idle();
      res = {p[1], p[0]} + {8'h00, p[2], 8'h00}
         + {8'h00, p[3], 8'h00};
      chk("wide high", 16'h0C37, res[31:16]);
      chk("wide low", 16'h4FA4, res[15:0]);
      $display("test wide done");
   endtask : t_wide
   task automatic conclude();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // reset, then each scenario
   initial begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      #1 chk("reset", 16'h0000, {ph, pl});
      t_mul();
      t_flags();
      t_write();
      t_signed();
      t_wide();
      conclude();
   end
endmodule : byte_hardware_multiplier_tb_top
